// File: verilog/pps_pkg.sv
// Shared constants for the preset pattern PWM sequencer
`default_nettype none
package pps_pkg;
	localparam int         PPS_NUM_CH      = 2;
	localparam int         PPS_NUM_PRESETS = 16;
	localparam int         PPS_IDX_W       = 4;
	localparam int         PPS_DUTY_W      = 8;
	localparam int         PPS_DIV_W       = 3;
	// Step clock sources
	localparam logic [1:0] PPS_STEP_MATRIX = 2'h0;
	localparam logic [1:0] PPS_STEP_OVF    = 2'h1;
	localparam logic [1:0] PPS_STEP_OVF2   = 2'h2;
	localparam logic [1:0] PPS_STEP_OVF8   = 2'h3;
	// Preset index ranges
	localparam logic [1:0] PPS_RANGE_ALL   = 2'h0;
	localparam logic [1:0] PPS_RANGE_LOWER = 2'h1;
	localparam logic [1:0] PPS_RANGE_UPPER = 2'h2;
	localparam logic [3:0] PPS_IDX_FIRST   = 4'h0;
	localparam logic [3:0] PPS_LOWER_LAST  = 4'h7;
	localparam logic [3:0] PPS_UPPER_FIRST = 4'h8;
	localparam logic [3:0] PPS_IDX_LAST    = 4'hf;
	// Period counter tops for 8-bit and 7-bit resolution
	localparam logic [7:0] PPS_PMAX8       = 8'hff;
	localparam logic [7:0] PPS_PMAX7       = 8'h7f;
	localparam logic [2:0] PPS_DIV2_BIT    = 3'h1;
	localparam logic [2:0] PPS_DIV8_LAST   = 3'h7;
	// Positions of the synchronised inputs
	localparam int         PPS_SB_STEP     = 0;
	localparam int         PPS_SB_DIR      = 1;
	localparam int         PPS_SB_HOLD     = 2;
	localparam int         PPS_SB_EXT      = 3;
	localparam logic [7:0] PPS_DUTY_RST    = 8'h00;
endpackage
`default_nettype wire

// File: verilog/pps_mem_if.sv
// Connection between the sequencer and its shared preset store
`timescale 1ns/1ps
`default_nettype none
interface pps_mem_if;
	logic                                       wr_en;
	logic [pps_pkg::PPS_IDX_W-1:0]              wr_addr;
	logic [pps_pkg::PPS_DUTY_W-1:0]             wr_data;
	logic [pps_pkg::PPS_NUM_CH-1:0][pps_pkg::PPS_IDX_W-1:0]  rd_addr;
	logic [pps_pkg::PPS_NUM_CH-1:0][pps_pkg::PPS_DUTY_W-1:0] rd_data;
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
	modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface
`default_nettype wire

// File: verilog/pps_preset_mem.sv
// Sixteen-byte preset store with one read port per channel
`timescale 1ns/1ps
`default_nettype none
module pps_preset_mem #(
	parameter int DEPTH = 16
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CE,
	pps_mem_if.mem   mif
);
	import pps_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][PPS_DUTY_W-1:0]      mem;
		logic [PPS_NUM_CH-1:0][PPS_DUTY_W-1:0] rd;
	} pps_mem_st_t;

	pps_mem_st_t st_reg;
	pps_mem_st_t st_next;

	// Refused at elaboration: the index width only reaches sixteen entries
	if (DEPTH != PPS_NUM_PRESETS) begin : g_bad_depth
		$error("Preset depth must match the index width");
	end

	always_comb begin
		st_next = st_reg;
		if (RST) begin
			st_next = '0;
		end else if (CE) begin
			if (mif.wr_en) begin
				st_next.mem[mif.wr_addr] = mif.wr_data;
			end
			// One store, read by both channels
			for (int c = 0; c < PPS_NUM_CH; c++) begin
				st_next.rd[c] = st_reg.mem[mif.rd_addr[c]];
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		st_reg <= st_next;
	end

	assign mif.rd_data = st_reg.rd;

	AST_SHARED_READ: assert property (@(posedge CORE_CLK) disable iff (RST)
		(CE && !mif.wr_en && mif.rd_addr[0] == mif.rd_addr[1]) |=> (mif.rd_data[0] == mif.rd_data[1]))
		else $error("Channels read different bytes from one entry");
	COV_SHARED: cover property (@(posedge CORE_CLK) disable iff (RST)
		CE && mif.rd_addr[0] == mif.rd_addr[1]);
endmodule
`default_nettype wire

// File: verilog/pps_sequencer.sv
// Two-channel PWM generator stepping through a shared preset table
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Preset mode takes duty from sixteen bytes
// - Step clock: matrix clock or period overflow
// - Each step changes the compared entry
// - One preset store serves both channels
// - Range: all, lower eight or upper eight
// - Start index held inside selected range
// - Direction high steps forward, low back
// - Hold freezes index; stop also freezes outputs
// - Step also overflow divided by two, eight
// - Period counter may use external clock
// - True output high until count reaches duty
// - Complement inverted, deadband delayed, polarity options
// - Eight-bit period counter, seven-bit option
module pps_sequencer #(
	parameter int DB_W = 8
) (
	input  wire logic                                 CORE_CLK,
	input  wire logic                                 RST,
	input  wire logic                                 CE,
	input  wire logic                                 PRESET_WE,
	input  wire logic [pps_pkg::PPS_IDX_W-1:0]        PRESET_ADDR,
	input  wire logic [pps_pkg::PPS_DUTY_W-1:0]       PRESET_DATA,
	input  wire logic [1:0]                           STEP_CLK,
	input  wire logic [1:0]                           STEP_DIR,
	input  wire logic [1:0]                           HOLD,
	input  wire logic [1:0]                           EXT_PERIOD_CLK,
	input  wire logic [1:0]                           PRESET_MODE,
	input  wire logic [1:0][1:0]                      STEP_SRC,
	input  wire logic [1:0]                           PERIOD_SRC,
	input  wire logic [1:0][1:0]                      RANGE_SEL,
	input  wire logic [1:0][pps_pkg::PPS_IDX_W-1:0]   INIT_IDX,
	input  wire logic [1:0][pps_pkg::PPS_DUTY_W-1:0]  INIT_DUTY,
	input  wire logic [1:0]                           STOP_MODE,
	input  wire logic [1:0]                           RES7,
	input  wire logic [1:0][DB_W-1:0]                 DEADBAND,
	input  wire logic [1:0]                           INV_P,
	input  wire logic [1:0]                           INV_N,
	output var  logic [1:0]                           PWM_P,
	output var  logic [1:0]                           PWM_N,
	output var  logic [1:0][pps_pkg::PPS_IDX_W-1:0]   PRESET_INDEX
);
	import pps_pkg::*;

	typedef struct packed {
		logic [1:0][3:0]            sy1;
		logic [1:0][3:0]            sy2;
		logic [1:0][3:0]            sy3;
		logic [1:0][7:0]            pcnt;
		logic [1:0][7:0]            duty;
		logic [1:0][7:0]            dcnt;
		logic [1:0][3:0]            idx;
		logic [1:0][PPS_DIV_W-1:0]  ovfdiv;
		logic [1:0][DB_W-1:0]       dbcnt;
		logic [1:0]                 nraw;
		logic [1:0]                 op;
		logic [1:0]                 on;
	} pps_st_t;

	pps_st_t    st_reg;
	pps_st_t    st_next;
	logic [1:0] step_ev;
	logic [1:0] ovf_ev;
	logic [1:0] frz_ev;
	pps_mem_if  mif ();

	// Refused at elaboration rather than at run time
	if (DB_W < 1 || DB_W > 16) begin : g_bad_db_w
		$error("Deadband width out of range");
	end

	assign mif.wr_en   = PRESET_WE;
	assign mif.wr_addr = PRESET_ADDR;
	assign mif.wr_data = PRESET_DATA;
	assign mif.rd_addr = st_reg.idx;

	pps_preset_mem #(
		.DEPTH (PPS_NUM_PRESETS)
	) u_mem (
		.CORE_CLK (CORE_CLK),
		.RST      (RST),
		.CE       (CE),
		.mif      (mif.mem)
	);

	always_comb begin
		logic       tick;
		logic       hld;
		logic       praw;
		logic       edge_m;
		logic [3:0] lo;
		logic [3:0] hi;
		logic [7:0] top;
		tick    = 1'b0;
		hld     = 1'b0;
		praw    = 1'b0;
		edge_m  = 1'b0;
		lo      = PPS_IDX_FIRST;
		hi      = PPS_IDX_LAST;
		top     = PPS_PMAX8;
		step_ev = '0;
		ovf_ev  = '0;
		frz_ev  = '0;
		st_next = st_reg;
		for (int c = 0; c < PPS_NUM_CH; c++) begin
			lo = (RANGE_SEL[c] == PPS_RANGE_UPPER) ? PPS_UPPER_FIRST : PPS_IDX_FIRST;
			hi = (RANGE_SEL[c] == PPS_RANGE_LOWER) ? PPS_LOWER_LAST : PPS_IDX_LAST;
			if (RST) begin
				st_next.idx[c] = INIT_IDX[c];
				if (RANGE_SEL[c] == PPS_RANGE_LOWER)
					st_next.idx[c][3] = 1'b0;
				if (RANGE_SEL[c] == PPS_RANGE_UPPER)
					st_next.idx[c][3] = 1'b1;
				st_next.dcnt[c]   = INIT_DUTY[c];
				st_next.duty[c]   = PPS_DUTY_RST;
				st_next.sy1[c]    = '0;
				st_next.sy2[c]    = '0;
				st_next.sy3[c]    = '0;
				st_next.pcnt[c]   = '0;
				st_next.ovfdiv[c] = '0;
				st_next.dbcnt[c]  = '0;
				st_next.nraw[c]   = 1'b0;
				st_next.op[c]     = 1'b0;
				st_next.on[c]     = 1'b0;
			end else if (CE) begin
				// Pins and matrix signals are asynchronous here
				st_next.sy1[c] = {EXT_PERIOD_CLK[c], HOLD[c], STEP_DIR[c], STEP_CLK[c]};
				st_next.sy2[c] = st_reg.sy1[c];
				st_next.sy3[c] = st_reg.sy2[c];
				tick = PERIOD_SRC[c] ? (st_reg.sy2[c][PPS_SB_EXT] & ~st_reg.sy3[c][PPS_SB_EXT])
					: 1'b1;
				hld       = st_reg.sy2[c][PPS_SB_HOLD];
				frz_ev[c] = hld & STOP_MODE[c];
				top       = RES7[c] ? PPS_PMAX7 : PPS_PMAX8;
				ovf_ev[c] = tick & (st_reg.pcnt[c] >= top);
				edge_m    = st_reg.sy2[c][PPS_SB_STEP] & ~st_reg.sy3[c][PPS_SB_STEP];
				unique case (STEP_SRC[c])
					PPS_STEP_MATRIX: step_ev[c] = edge_m;
					PPS_STEP_OVF:    step_ev[c] = ovf_ev[c];
					PPS_STEP_OVF2:   step_ev[c] = ovf_ev[c] & st_reg.ovfdiv[c][0];
					PPS_STEP_OVF8:   step_ev[c] = ovf_ev[c] & (st_reg.ovfdiv[c] == PPS_DIV8_LAST);
				endcase
				if (ovf_ev[c])
					st_next.ovfdiv[c] = st_reg.ovfdiv[c] + PPS_DIV2_BIT;
				if (tick)
					st_next.pcnt[c] = ovf_ev[c] ? 8'h00 : st_reg.pcnt[c] + 8'h01;
				// New duty is applied only at a period boundary, never mid-period
				if (ovf_ev[c])
					st_next.duty[c] = PRESET_MODE[c] ? mif.rd_data[c] : st_reg.dcnt[c];
				if (step_ev[c] && !hld) begin
					if (PRESET_MODE[c]) begin
						if (st_reg.sy2[c][PPS_SB_DIR]) begin
							st_next.idx[c] = (st_reg.idx[c] >= hi || st_reg.idx[c] < lo) ? lo
								: st_reg.idx[c] + 4'h1;
						end else begin
							st_next.idx[c] = (st_reg.idx[c] <= lo || st_reg.idx[c] > hi) ? hi
								: st_reg.idx[c] - 4'h1;
						end
					end else begin
						st_next.dcnt[c] = st_reg.sy2[c][PPS_SB_DIR] ? st_reg.dcnt[c] + 8'h01
							: st_reg.dcnt[c] - 8'h01;
					end
				end
				praw = RES7[c] ? (st_reg.pcnt[c][6:0] < st_reg.duty[c][7:1])
					: (st_reg.pcnt[c] < st_reg.duty[c]);
				if (!frz_ev[c]) begin
					// Complement rises only after the deadband, falls at once
					if (praw) begin
						st_next.nraw[c]  = 1'b0;
						st_next.dbcnt[c] = '0;
					end else if (st_reg.dbcnt[c] >= DEADBAND[c]) begin
						st_next.nraw[c] = 1'b1;
					end else begin
						st_next.dbcnt[c] = st_reg.dbcnt[c] + 1'b1;
					end
					st_next.op[c] = praw ^ INV_P[c];
					st_next.on[c] = (st_next.nraw[c] & ~praw) ^ INV_N[c];
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		st_reg <= st_next;
	end

	assign PWM_P        = st_reg.op;
	assign PWM_N        = st_reg.on;
	assign PRESET_INDEX = st_reg.idx;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	for (genvar g = 0; g < 2; g++) begin
		AST_STEP_UP: assert property ((CE && step_ev[g] && !st_reg.sy2[g][PPS_SB_HOLD]
			&& PRESET_MODE[g] && st_reg.sy2[g][PPS_SB_DIR] && RANGE_SEL[g] == PPS_RANGE_ALL
			&& st_reg.idx[g] != PPS_IDX_LAST) |=> (st_reg.idx[g] == $past(st_reg.idx[g]) + 4'h1))
			else $error("Forward step did not select next entry");
		AST_STEP_DOWN: assert property ((CE && step_ev[g] && !st_reg.sy2[g][PPS_SB_HOLD]
			&& PRESET_MODE[g] && !st_reg.sy2[g][PPS_SB_DIR] && RANGE_SEL[g] == PPS_RANGE_ALL
			&& st_reg.idx[g] != PPS_IDX_FIRST) |=> (st_reg.idx[g] == $past(st_reg.idx[g]) - 4'h1))
			else $error("Backward step did not select previous entry");
		AST_WRAP_LOWER: assert property ((CE && step_ev[g] && !st_reg.sy2[g][PPS_SB_HOLD]
			&& PRESET_MODE[g] && st_reg.sy2[g][PPS_SB_DIR] && RANGE_SEL[g] == PPS_RANGE_LOWER
			&& st_reg.idx[g] == PPS_LOWER_LAST) |=> (st_reg.idx[g] == PPS_IDX_FIRST))
			else $error("Index did not wrap inside lower range");
		AST_RANGE_UPPER: assert property ((RANGE_SEL[g] == PPS_RANGE_UPPER
			&& st_reg.idx[g][3] && $stable(RANGE_SEL[g])) |=> st_reg.idx[g][3])
			else $error("Index left the upper range");
		AST_HOLD_IDX: assert property ((CE && st_reg.sy2[g][PPS_SB_HOLD]) |=>
			$stable(st_reg.idx[g]) && $stable(st_reg.dcnt[g]))
			else $error("Index moved during hold");
		AST_STOP_OUT: assert property ((CE && frz_ev[g]) |=>
			$stable(PWM_P[g]) && $stable(PWM_N[g]))
			else $error("Outputs moved during stop");
		AST_PRESET_DUTY: assert property ((CE && ovf_ev[g] && PRESET_MODE[g]) |=>
			(st_reg.duty[g] == $past(mif.rd_data[g])) && st_reg.pcnt[g] == 8'h00)
			else $error("Period did not take its duty from the preset");
		AST_RES7_WRAP: assert property ((CE && RES7[g] && !PERIOD_SRC[g]
			&& st_reg.pcnt[g] == PPS_PMAX7) |=> st_reg.pcnt[g] == 8'h00)
			else $error("Seven-bit period did not wrap at 127");
		AST_DIV8: assert property ((CE && STEP_SRC[g] == PPS_STEP_OVF8 && step_ev[g]) |->
			ovf_ev[g] ##1 (st_reg.ovfdiv[g] == 3'h0))
			else $error("Divided step off its eighth overflow");
		AST_EXT_CLK: assert property ((CE && PERIOD_SRC[g] &&
			!(st_reg.sy2[g][PPS_SB_EXT] && !st_reg.sy3[g][PPS_SB_EXT])) |=> $stable(st_reg.pcnt[g]))
			else $error("Period counter moved without external edge");
		AST_START_HIGH: assert property ((CE && !frz_ev[g] && !INV_P[g] && !RES7[g]
			&& st_reg.pcnt[g] == 8'h00 && st_reg.duty[g] != 8'h00) |=> PWM_P[g])
			else $error("True output low at period start");
		AST_NO_OVERLAP: assert property ((CE && !frz_ev[g] && !INV_P[g] && !INV_N[g])
			|=> !(PWM_P[g] && PWM_N[g]))
			else $error("True and complement outputs overlap");
		COV_STEP: cover property (CE && step_ev[g] && PRESET_MODE[g]);
		COV_WRAP: cover property (CE && step_ev[g] && st_reg.idx[g] == PPS_IDX_LAST);
		COV_STOP: cover property (CE && frz_ev[g] ##1 !frz_ev[g]);
	end
endmodule
`default_nettype wire

// File: sim/pps_matrix_model.sv
// Behavioural logic matrix: step pulses on request and a free-running period clock
`timescale 1ns/1ps
`default_nettype none
module pps_matrix_model (
	input  wire logic clk,
	input  wire logic fire,
	output wire logic step,
	output wire logic ext_clk
);
	logic [2:0] cnt_reg = 3'h0;
	logic [1:0] div_reg = 2'h0;
	// Pulse is high three cycles, then low; wider than the input sync needs
	always_ff @(posedge clk) begin
		if (fire)
			cnt_reg <= 3'h7;
		else if (cnt_reg != 3'h0)
			cnt_reg <= cnt_reg - 3'h1;
		div_reg <= div_reg + 2'h1;
	end
	assign step    = (cnt_reg > 3'h4);
	// External period clock runs free at a quarter of the core rate
	assign ext_clk = div_reg[1];
endmodule
`default_nettype wire

// File: sim/pwm_preset_pattern_sequencer_tb_top.sv
// Self-checking bench for the preset pattern PWM sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("MISMATCH t=%0t %s", $time, m); end end
module pwm_preset_pattern_sequencer_tb_top;
	import pps_pkg::*;
	typedef struct packed {logic [1:0] rng; logic dir; logic [3:0] exp;} pps_row_t;
	typedef struct packed {logic [1:0] src; logic psrc; logic r7; int n;} pps_rate_t;
	logic            core_clk, rst, ce, preset_we, fire, mstep, mext, last_p;
	logic [3:0]      preset_addr;
	logic [7:0]      preset_data;
	logic [1:0]      step_clk, step_dir, hold, ext_period_clk, preset_mode, period_src;
	logic [1:0]      stop_mode, res7, inv_p, inv_n, pwm_p, pwm_n;
	logic [1:0][1:0] step_src, range_sel;
	logic [1:0][3:0] init_idx, preset_index;
	logic [1:0][7:0] init_duty, deadband;
	logic [3:0]      last_idx, last_out;
	int              n_errors, samples_checked, cp0, cn0, cp1, cn1, ov, chg;
	pps_row_t rows [10] = '{'{PPS_RANGE_UPPER, 1'b1, 4'hf}, '{PPS_RANGE_UPPER, 1'b1, 4'h8},
		'{PPS_RANGE_UPPER, 1'b0, 4'hf}, '{PPS_RANGE_ALL, 1'b1, 4'h0}, '{PPS_RANGE_ALL, 1'b0, 4'hf},
		'{PPS_RANGE_ALL, 1'b0, 4'he}, '{PPS_RANGE_ALL, 1'b1, 4'hf},
		'{PPS_RANGE_LOWER, 1'b1, 4'h0}, '{PPS_RANGE_LOWER, 1'b0, 4'h7}, '{PPS_RANGE_LOWER, 1'b1, 4'h0}};
	// Index changes seen in a 4096-cycle window for each overflow-driven step source
	pps_rate_t rates [5] = '{'{PPS_STEP_OVF, 1'b0, 1'b0, 16}, '{PPS_STEP_OVF2, 1'b0, 1'b0, 8},
		'{PPS_STEP_OVF8, 1'b0, 1'b0, 2}, '{PPS_STEP_OVF, 1'b1, 1'b0, 4}, '{PPS_STEP_OVF, 1'b0, 1'b1, 32}};
	assign step_clk       = {1'b0, mstep};
	assign ext_period_clk = {mext, 1'b0};
	pps_matrix_model u_matrix (.clk(core_clk), .fire(fire), .step(mstep), .ext_clk(mext));
	pps_sequencer uut (.CORE_CLK(core_clk), .RST(rst), .CE(ce), .PRESET_WE(preset_we),
		.PRESET_ADDR(preset_addr), .PRESET_DATA(preset_data), .STEP_CLK(step_clk),
		.STEP_DIR(step_dir), .HOLD(hold), .EXT_PERIOD_CLK(ext_period_clk),
		.PRESET_MODE(preset_mode), .STEP_SRC(step_src), .PERIOD_SRC(period_src),
		.RANGE_SEL(range_sel), .INIT_IDX(init_idx), .INIT_DUTY(init_duty), .STOP_MODE(stop_mode),
		.RES7(res7), .DEADBAND(deadband), .INV_P(inv_p), .INV_N(inv_n), .PWM_P(pwm_p),
		.PWM_N(pwm_n), .PRESET_INDEX(preset_index));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Waits past a period boundary so the new duty applies, then counts one full period
	task automatic measure();
		cp0 = 0; cn0 = 0; cp1 = 0; cn1 = 0; ov = 0;
		tick(260);
		repeat (256) begin
			cp0 += int'(pwm_p[0]); cn0 += int'(pwm_n[0]); cp1 += int'(pwm_p[1]);
			cn1 += int'(pwm_n[1]); ov += int'(pwm_p[0] & pwm_n[0]);
			tick(1);
		end
	endtask
	task automatic step0(input logic d);
		step_dir[0] = d; fire = 1'b1;
		tick(1);
		fire = 1'b0;
		tick(10);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#(60000 * 20);
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		rst = 1'b1; ce = 1'b1; preset_we = 1'b0; fire = 1'b0; preset_addr = 4'h0; preset_data = 8'h00;
		step_dir = 2'h3; hold = 2'h0; preset_mode = 2'h3; period_src = 2'h0; stop_mode = 2'h0;
		res7 = 2'h0; inv_p = 2'h0; inv_n = 2'h0; step_src = '0; init_duty = '0;
		range_sel = {PPS_RANGE_LOWER, PPS_RANGE_UPPER}; init_idx = {4'hc, 4'h6};
		deadband = {8'h00, 8'h04};
		tick(16);
		`CHK(preset_index[0], 4'he, "start index upper")
		`CHK(preset_index[1], 4'h4, "start index lower")
		`CHK({pwm_p, pwm_n}, 4'h0, "outputs in reset")
		rst = 1'b0;
		for (int i = 0; i < 16; i++) begin
			preset_we = 1'b1; preset_addr = 4'(i); preset_data = 8'(16 * i + 8);
			tick(1);
		end
		preset_we = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			range_sel[0] = rows[i].rng;
			step0(rows[i].dir);
			`CHK(preset_index[0], rows[i].exp, "index after step")
			measure();
			`CHK(cp0, 16 * int'(rows[i].exp) + 8, "duty from preset")
			`CHK(cp1, 72, "second channel reads shared store")
			`CHK(ov, 0, "outputs overlap")
			`CHK(cn0, 256 - cp0 - int'(deadband[0]), "complement width")
			`CHK(cn1, 256 - cp1 - int'(deadband[1]), "complement width no deadband")
		end
		$display("step table test done");
		hold[0] = 1'b1; stop_mode[0] = 1'b1;
		tick(4);
		last_idx = preset_index[0]; last_p = pwm_p[0]; chg = 0;
		step0(1'b1);
		repeat (300) begin
			chg += int'(pwm_p[0] !== last_p);
			tick(1);
		end
		`CHK(preset_index[0], last_idx, "index moved in hold")
		`CHK(chg, 0, "output moved in stop")
		hold[0] = 1'b0; stop_mode[0] = 1'b0;
		tick(4);
		step0(1'b1);
		`CHK(preset_index[0], 4'h1, "step after hold")
		inv_p[0] = 1'b1; inv_n[0] = 1'b1;
		measure();
		`CHK(cp0, 232, "inverted true output")
		`CHK(cn0, 256 - cp0 + int'(deadband[0]), "inverted complement")
		$display("hold and polarity test done");
		// Step pulse arrives while the enable is low and must leave no trace
		ce = 1'b0; last_idx = preset_index[0]; last_out = {pwm_p, pwm_n}; chg = 0;
		step0(1'b1);
		repeat (300) begin
			chg += int'({pwm_p, pwm_n} !== last_out);
			tick(1);
		end
		`CHK(preset_index[0], last_idx, "index moved with clock enable low")
		`CHK(chg, 0, "outputs moved with clock enable low")
		ce = 1'b1;
		$display("clock enable test done");
		// Settle after each source change, since the divider phase is unknown at the switch
		foreach (rates[i]) begin
			step_src[1] = rates[i].src; period_src[1] = rates[i].psrc; res7[1] = rates[i].r7;
			tick(2048);
			chg = 0;
			last_idx = preset_index[1];
			repeat (4096) begin
				tick(1);
				chg += int'(preset_index[1] !== last_idx);
				last_idx = preset_index[1];
			end
			`CHK(chg, rates[i].n, "overflow step rate")
		end
		$display("step source test done");
		// Mid-run reset: clamps the start index, clears the store, restarts the duty counter
		inv_p[0] = 1'b0; inv_n[0] = 1'b0; preset_mode[0] = 1'b0; init_duty[0] = 8'h40;
		init_idx[0] = 4'hc; rst = 1'b1;
		tick(2);
		`CHK(preset_index[0], 4'h4, "index clamp in second reset")
		`CHK({pwm_p, pwm_n}, 4'h0, "outputs in second reset")
		rst = 1'b0;
		tick(1);
		`CHK(pwm_p, 2'h0, "true outputs after release")
		measure();
		`CHK(cp0, int'(init_duty[0]), "duty from duty step counter")
		`CHK(cp1, 0, "preset store cleared by reset")
		step0(1'b0);
		measure();
		`CHK(cp0, int'(init_duty[0]) - 1, "duty step counter stepped down")
		$display("second reset test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
